//--- design/ukirq_pkg.sv
package ukirq_pkg;
  localparam logic [15:0] UKIRQ_TIMER_FLAGS_ADDR = 16'h0038;
  localparam logic [15:0] UKIRQ_ENABLE_ADDR = 16'h1ff3;
  localparam logic [15:0] UKIRQ_ACK_ADDR = 16'h1ff5;
  localparam logic [15:0] UKIRQ_MASK_ADDR = 16'h1ff6;
  localparam logic [15:0] UKIRQ_STATUS_ADDR = 16'h1ff7;
  localparam logic [15:0] UKIRQ_SUSRES_ADDR = 16'h1ffa;
  localparam logic [15:0] UKIRQ_SUSRES_EN_ADDR = 16'h1ff9;
  localparam logic [15:0] UKIRQ_SLEEP_CTRL_ADDR = 16'h1ff0;
  localparam logic [15:0] UKIRQ_CORE_CTRL_ADDR = 16'h1ff1;
  localparam int UKIRQ_TOV_BIT = 1;
  localparam int UKIRQ_SLEEP_ALLOW_BIT = 5;
  localparam int UKIRQ_SLEEP_DEPTH_BIT = 4;
  localparam logic [7:0] UKIRQ_USB_IMPL = 8'hcf;
  localparam logic [7:0] UKIRQ_SUSRES_IMPL = 8'h07;
  localparam logic [7:0] UKIRQ_RESET_VAL = 8'h00;
  localparam int UKIRQ_ENTRY_CYCLES = 4;
  localparam int UKIRQ_RETURN_CYCLES = 4;
  localparam int UKIRQ_JUMP_CYCLES = 3;
  localparam int UKIRQ_EOF_LEAD_CLOCKS = 10;

  typedef enum logic [2:0] {
    UKIRQ_RUN = 3'b000,
    UKIRQ_ENTRY = 3'b001,
    UKIRQ_JUMP = 3'b011,
    UKIRQ_RETURN = 3'b010,
    UKIRQ_AFTER_RET = 3'b110
  } ukirq_state_t;

  // endpoint status-register events from the usb engine
  typedef struct packed {
    logic rx_out_set;
    logic tx_ready_clr_complete_set;
    logic rx_setup_set;
    logic tx_complete_set;
  } ukirq_ep_evt_t;

  typedef struct packed {
    logic [15:0] pc;
    logic [15:0] sp;
  } ukirq_ctx_t;
endpackage

//--- design/ukirq_top.sv
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/1ps
module ukirq_top
  import ukirq_pkg::*;
#(
  parameter int FRAME_CLOCKS = 12000
)(
  input wire logic hclk, // core clock
  input wire logic hresetn, // async reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write
  input wire logic [2:0] hsize, // size
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic [31:0] hrdata, // read data
  output logic hreadyout, // slave ready
  output logic hresp, // always okay
  input wire logic timer_overflow, // timer wrap pulse
  input wire logic sof_valid, // valid frame start pulse
  input wire logic [10:0] sof_frame_num, // decoded frame number
  input wire ukirq_ep_evt_t hub_ep0_evt, // hub endpoint 0 events
  input wire ukirq_ep_evt_t [2:0] func_ep_evt, // function endpoint events
  input wire logic function_wakeup_request, // remote wakeup pulse
  input wire logic global_suspend_event, // suspend pulse
  input wire logic resume_event, // resume pulse
  input wire logic [7:0] key_rows_n, // key matrix rows, low pressed
  input wire logic in_suspend, // device suspended
  input wire logic instr_boundary, // core at instruction boundary
  input wire logic sleep_instr, // sleep instruction executing
  input wire logic [15:0] pc_in, // next pc of running code
  output logic [15:0] frame_number, // stored frame number
  output logic usb_irq_req, // combined usb request
  output logic susres_irq_req, // suspend/resume request
  output logic vector_taken, // pulse when vector reached
  output logic in_irq_seq, // core stalled for entry/return
  output logic [15:0] stack_ptr, // stack pointer
  output logic sleep_power_down, // core asleep
  output logic global_irq_enable // core flags register bit 7
);
  initial
  begin
    if (FRAME_CLOCKS <= UKIRQ_EOF_LEAD_CLOCKS || FRAME_CLOCKS > 65535)
      $error("FRAME_CLOCKS out of range");
  end

  logic [7:0] key_s1_ff, key_s2_ff;
  logic tov_ff, timer_ie_ff, gie_ff;
  logic [7:0] usb_stat_ff, usb_en_ff, usb_mask_ff;
  logic [7:0] sr_stat_ff, sr_en_ff, sr_mask_ff;
  logic [7:0] sleep_ctrl_ff;
  logic [15:0] frame_ff, frame_cnt_ff, sp_ff, ret_pc_ff;
  logic sleep_ff;
  ukirq_state_t state_ff;
  logic [2:0] cnt_ff;
  logic wr_pend_ff;
  logic [15:0] addr_ff;
  logic [31:0] rdata_ff;
  logic [7:0] wdat;
  logic wr_tov, wr_timer_ie, wr_ack, wr_mask, wr_en, wr_sr, wr_sr_en, wr_sleep, wr_core;
  logic [7:0] usb_set, sr_set;
  logic key_hit, eof_hit, timer_req, take_irq;
  logic [7:0] rd_val;

  // key rows into the core domain pass two flops first
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      key_s1_ff <= 8'hff;
      key_s2_ff <= 8'hff;
    end
    else
    begin
      key_s1_ff <= key_rows_n;
      key_s2_ff <= key_s1_ff;
    end
  end

  // bus: address phase captured, zero-wait write/read next cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_ff <= 1'b0;
      addr_ff <= 16'h0000;
    end
    else if (hready)
    begin
      wr_pend_ff <= hsel && htrans[1] && hwrite;
      addr_ff <= haddr[17:2];
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign wdat = hwdata[7:0];
  assign wr_tov = wr_pend_ff && addr_ff == UKIRQ_TIMER_FLAGS_ADDR;
  assign wr_timer_ie = wr_pend_ff && addr_ff == UKIRQ_CORE_CTRL_ADDR;
  assign wr_ack = wr_pend_ff && addr_ff == UKIRQ_ACK_ADDR;
  assign wr_mask = wr_pend_ff && addr_ff == UKIRQ_MASK_ADDR;
  assign wr_en = wr_pend_ff && addr_ff == UKIRQ_ENABLE_ADDR;
  assign wr_sr = wr_pend_ff && addr_ff == UKIRQ_SUSRES_ADDR;
  assign wr_sr_en = wr_pend_ff && addr_ff == UKIRQ_SUSRES_EN_ADDR;
  assign wr_sleep = wr_pend_ff && addr_ff == UKIRQ_SLEEP_CTRL_ADDR;
  assign wr_core = wr_timer_ie;

  // timer interrupt enable
  // enable sits at the flag's bit position, so one constant serves both
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      timer_ie_ff <= 1'b0;
    else if (wr_timer_ie)
      timer_ie_ff <= wdat[UKIRQ_TOV_BIT];
  end

  // index registers: byte address is four times the printed offset
  always_comb
  begin
    case (haddr[17:2])
      UKIRQ_TIMER_FLAGS_ADDR: rd_val = {6'h00, tov_ff, 1'b0};
      UKIRQ_CORE_CTRL_ADDR: rd_val = {gie_ff, 5'h00, timer_ie_ff, 1'b0};
      UKIRQ_ENABLE_ADDR: rd_val = usb_en_ff;
      UKIRQ_MASK_ADDR: rd_val = usb_mask_ff;
      UKIRQ_STATUS_ADDR: rd_val = usb_stat_ff;
      UKIRQ_SUSRES_ADDR: rd_val = sr_stat_ff;
      UKIRQ_SUSRES_EN_ADDR: rd_val = {sr_mask_ff[3:0], sr_en_ff[3:0]};
      UKIRQ_SLEEP_CTRL_ADDR: rd_val = sleep_ctrl_ff;
      default: rd_val = 8'h00;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      rdata_ff <= 32'h00000000;
    else if (hready && hsel && htrans[1] && !hwrite)
      rdata_ff <= {24'h000000, rd_val};
  end
  assign hrdata = rdata_ff;

  function automatic logic ep_fire(input ukirq_ep_evt_t e);
    ep_fire = |e;
  endfunction

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      frame_cnt_ff <= 16'h0000;
    else if (sof_valid)
      frame_cnt_ff <= 16'h0001;
    else if (frame_cnt_ff == 16'(FRAME_CLOCKS - 1))
      frame_cnt_ff <= 16'h0000;
    else
      frame_cnt_ff <= frame_cnt_ff + 16'h0001;
  end
  assign eof_hit = frame_cnt_ff == 16'(FRAME_CLOCKS - UKIRQ_EOF_LEAD_CLOCKS);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      frame_ff <= 16'h0000;
    else if (sof_valid)
      frame_ff <= {5'h00, sof_frame_num};
  end
  assign frame_number = frame_ff;

  always_comb
  begin
    usb_set = 8'h00;
    usb_set[7] = sof_valid;
    usb_set[6] = eof_hit;
    usb_set[3] = ep_fire(hub_ep0_evt);
    usb_set[2] = ep_fire(func_ep_evt[2]);
    usb_set[1] = ep_fire(func_ep_evt[1]);
    usb_set[0] = ep_fire(func_ep_evt[0]);
  end

  // acknowledge clears; set wins over clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      usb_stat_ff <= UKIRQ_RESET_VAL;
    else
      usb_stat_ff <= ((usb_stat_ff & ~(wr_ack ? wdat : 8'h00)) | usb_set) & UKIRQ_USB_IMPL;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      usb_en_ff <= UKIRQ_RESET_VAL;
      usb_mask_ff <= UKIRQ_RESET_VAL;
    end
    else
    begin
      if (wr_en)
        usb_en_ff <= wdat & UKIRQ_USB_IMPL;
      if (wr_mask)
        usb_mask_ff <= wdat & UKIRQ_USB_IMPL;
    end
  end

  assign usb_irq_req = |(usb_stat_ff & usb_en_ff & ~usb_mask_ff);

  assign key_hit = in_suspend && (key_s2_ff != 8'hff);

  always_comb
  begin
    sr_set = 8'h00;
    sr_set[2] = function_wakeup_request;
    sr_set[1] = resume_event || key_hit;
    sr_set[0] = global_suspend_event;
  end

  // written zero clears, one keeps; set wins
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      sr_stat_ff <= UKIRQ_RESET_VAL;
    else
      sr_stat_ff <= ((sr_stat_ff & (wr_sr ? wdat : 8'hff)) | sr_set) & UKIRQ_SUSRES_IMPL;
  end

  // mask here: one makes the event visible
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sr_en_ff <= UKIRQ_RESET_VAL;
      sr_mask_ff <= UKIRQ_RESET_VAL;
    end
    else if (wr_sr_en)
    begin
      sr_en_ff <= {4'h0, wdat[3:0]} & UKIRQ_SUSRES_IMPL;
      sr_mask_ff <= {4'h0, wdat[7:4]} & UKIRQ_SUSRES_IMPL;
    end
  end
  assign susres_irq_req = |(sr_stat_ff & sr_en_ff & sr_mask_ff);

  assign timer_req = gie_ff && timer_ie_ff && tov_ff;
  // not in the instruction right after return
  assign take_irq = timer_req && instr_boundary && state_ff == UKIRQ_RUN && !sleep_ff;

  // overflow sets; one clears; taking the interrupt clears
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      tov_ff <= 1'b0;
    else if (timer_overflow)
      tov_ff <= 1'b1;
    else if ((wr_tov && wdat[UKIRQ_TOV_BIT]) || take_irq)
      tov_ff <= 1'b0;
  end

  // core state: entry, jump, return sequencing
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_ff <= UKIRQ_RUN;
      cnt_ff <= 3'h0;
      sp_ff <= 16'h0000;
      ret_pc_ff <= 16'h0000;
      gie_ff <= 1'b0;
    end
    else
    begin
      case (state_ff)
        UKIRQ_RUN:
        begin
          if (take_irq)
          begin
            state_ff <= UKIRQ_ENTRY;
            cnt_ff <= 3'(UKIRQ_ENTRY_CYCLES - 1);
            ret_pc_ff <= pc_in;
            sp_ff <= sp_ff - 16'h0002;
            gie_ff <= 1'b0;
          end
          else if (wr_core)
            gie_ff <= wdat[7];
        end
        UKIRQ_ENTRY:
        begin
          cnt_ff <= cnt_ff - 3'h1;
          if (cnt_ff == 3'h1)
          begin
            state_ff <= UKIRQ_JUMP;
            cnt_ff <= 3'(UKIRQ_JUMP_CYCLES);
          end
        end
        UKIRQ_JUMP:
        begin
          cnt_ff <= cnt_ff - 3'h1;
          if (cnt_ff == 3'h1)
          begin
            // return: pop pc, sp+2, enable on
            state_ff <= UKIRQ_RETURN;
            cnt_ff <= 3'(UKIRQ_RETURN_CYCLES);
          end
        end
        UKIRQ_RETURN:
        begin
          cnt_ff <= cnt_ff - 3'h1;
          if (cnt_ff == 3'h1)
          begin
            state_ff <= UKIRQ_AFTER_RET;
            sp_ff <= sp_ff + 16'h0002;
            gie_ff <= 1'b1;
          end
        end
        UKIRQ_AFTER_RET:
        begin
          if (instr_boundary)
            state_ff <= UKIRQ_RUN;
        end
        default: state_ff <= UKIRQ_RUN;
      endcase
    end
  end

  assign vector_taken = state_ff == UKIRQ_ENTRY && cnt_ff == 3'h1;
  assign in_irq_seq = state_ff != UKIRQ_RUN && state_ff != UKIRQ_AFTER_RET;
  assign stack_ptr = sp_ff;
  assign global_irq_enable = gie_ff;

  // sleep control register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      sleep_ctrl_ff <= UKIRQ_RESET_VAL;
    else if (wr_sleep)
      sleep_ctrl_ff <= wdat & 8'h30;
  end

  // sleep needs allow bit; only power-down honoured
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      sleep_ff <= 1'b0;
    else if (key_hit || usb_irq_req || susres_irq_req)
      sleep_ff <= 1'b0;
    else if (sleep_instr && sleep_ctrl_ff[UKIRQ_SLEEP_ALLOW_BIT]
             && sleep_ctrl_ff[UKIRQ_SLEEP_DEPTH_BIT])
      sleep_ff <= 1'b1;
  end
  assign sleep_power_down = sleep_ff;
endmodule

//--- verification/ukirq_chk.sv
`timescale 1ns/1ps
module ukirq_chk
  import ukirq_pkg::*;
(
  input wire logic hclk, // clock
  input wire logic hresetn, // reset
  input wire logic hsel, // select
  input wire logic [31:0] haddr, // address
  input wire logic [1:0] htrans, // transfer
  input wire logic hwrite, // write
  input wire logic hready, // ready in
  input wire logic [31:0] hrdata, // read data
  input wire logic sof_valid, // frame start
  input wire logic [10:0] sof_frame_num, // frame number in
  input wire logic instr_boundary, // boundary
  input wire logic sleep_instr, // sleep op
  input wire logic [15:0] frame_number, // stored number
  input wire logic vector_taken, // vector reached
  input wire logic in_irq_seq, // stall
  input wire logic sleep_power_down, // asleep
  input wire logic global_irq_enable // global enable
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic rd_req;
  assign rd_req = hsel && hready && htrans[1] && !hwrite;
  rd_upper_zero_a: assert property (rd_req |=> hrdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  tf_reserved_a: assert property (rd_req && haddr[17:2] == UKIRQ_TIMER_FLAGS_ADDR
    |=> hrdata[7:2] == 6'h0 && !hrdata[0]) else $error("timer flag reserved bit set");
  st_reserved_a: assert property (rd_req && haddr[17:2] == UKIRQ_STATUS_ADDR
    |=> hrdata[5:4] == 2'h0) else $error("status reserved bit set");
  frame_num_a: assert property (sof_valid |=> frame_number == {5'h0, $past(sof_frame_num)})
    else $error("frame number not stored");
  entry_len_a: assert property ($fell(global_irq_enable) && in_irq_seq |-> ##[2:4] vector_taken)
    else $error("vector late");
  gie_clear_a: assert property (vector_taken |-> in_irq_seq && !global_irq_enable)
    else $error("global enable set at vector");
  gie_set_a: assert property (vector_taken |-> ##[1:12] global_irq_enable)
    else $error("return did not set global enable");
  entry_bound_a: assert property ($fell(global_irq_enable) && in_irq_seq |-> $past(instr_boundary))
    else $error("entry inside an instruction");
  after_ret_a: assert property ($fell(in_irq_seq) |-> !in_irq_seq[*2])
    else $error("no instruction after return");
  sleep_cause_a: assert property ($rose(sleep_power_down) |-> $past(sleep_instr))
    else $error("sleep without sleep op");
  cover property (vector_taken);
  cover property ($rose(sleep_power_down));
  cover property (sof_valid);
endmodule
bind ukirq_top ukirq_chk u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready,
  .hrdata, .sof_valid, .sof_frame_num, .instr_boundary, .sleep_instr, .frame_number,
  .vector_taken, .in_irq_seq, .sleep_power_down, .global_irq_enable);

//--- verification/ukirq_core_model.sv
`timescale 1ns/1ps
module ukirq_core_model (
  input wire logic hclk, // core clock
  input wire logic hresetn, // reset, active low
  input wire logic in_irq_seq, // core stalled by entry or return
  input wire logic sleep_go, // firmware reaches its sleep op
  output logic instr_boundary, // interrupt may be taken
  output logic sleep_instr, // sleep op executing
  output logic [15:0] pc_in // next pc
);
  logic [1:0] phase_ff;
  logic [15:0] pc_ff;
  logic slp_ff;
  // every second op spans three cycles
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      phase_ff <= 2'h0;
    else if (!in_irq_seq)
      phase_ff <= phase_ff + 2'h1;
  assign instr_boundary = !in_irq_seq && phase_ff != 2'h1 && phase_ff != 2'h2;
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      pc_ff <= 16'h0;
    else if (instr_boundary)
      pc_ff <= pc_ff + 16'h1;
  assign pc_in = pc_ff;
  // op follows the settings written just before
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      slp_ff <= 1'b0;
    else
      slp_ff <= sleep_go && !slp_ff;
  assign sleep_instr = slp_ff;
endmodule

//--- verification/usb_keyboard_irq_unit_tb.sv
`timescale 1ns/1ps
module usb_keyboard_irq_unit_tb;
  import ukirq_pkg::*;
  localparam int FRAME_CLOCKS = 40;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hready, hreadyout, hresp;
  logic [31:0] haddr = 0, hwdata = 0, hrdata;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic timer_overflow = 0, sof_valid = 0, in_suspend = 0, sleep_go = 0;
  logic function_wakeup_request = 0, global_suspend_event = 0, resume_event = 0;
  logic [10:0] sof_frame_num = 0;
  ukirq_ep_evt_t hub_ep0_evt = '0;
  ukirq_ep_evt_t [2:0] func_ep_evt = '0;
  logic [7:0] key_rows_n = 8'hff;
  logic instr_boundary, sleep_instr, usb_irq_req, susres_irq_req, vector_taken, in_irq_seq;
  logic sleep_power_down, global_irq_enable;
  logic [15:0] pc_in, frame_number, stack_ptr;
  int failures = 0, total_checks = 0, cycles = 0;
  integer seed = 32'h8d1d5d23;
  ukirq_top #(.FRAME_CLOCKS(FRAME_CLOCKS)) uut (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .timer_overflow,
    .sof_valid, .sof_frame_num, .hub_ep0_evt, .func_ep_evt, .function_wakeup_request,
    .global_suspend_event, .resume_event, .key_rows_n, .in_suspend, .instr_boundary,
    .sleep_instr, .pc_in, .frame_number, .usb_irq_req, .susres_irq_req, .vector_taken,
    .in_irq_seq, .stack_ptr, .sleep_power_down, .global_irq_enable);
  ukirq_core_model core (.hclk, .hresetn, .in_irq_seq, .sleep_go, .instr_boundary,
    .sleep_instr, .pc_in);
  always #2.5 hclk = ~hclk;
  // the one slave's ready is the bus ready
  assign hready = hreadyout;
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // a hang ends the run through the same report
  always @(posedge hclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      failures++;
      conclude();
    end
  end
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    total_checks++;
    if (s !== e)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d,
    output logic [7:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {14'h0, a, 2'b00};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata[7:0];
    #1;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    logic [7:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rc(input logic [15:0] a, input logic [7:0] e, input logic [7:0] m);
    logic [7:0] r;
    bus(1'b0, a, 8'h0, r);
    chk("register", {8'h0, r & m}, {8'h0, e & m});
  endtask
  function automatic logic [7:0] ep_bit(input int i);
    return (i == 3) ? 8'h08 : (8'h01 << i);
  endfunction
  initial
  begin
    logic [7:0] st, ack;
    logic [3:0] ev;
    logic [15:0] sp0;
    logic pushed;
    logic [15:0] regs [10] = '{UKIRQ_TIMER_FLAGS_ADDR, UKIRQ_ENABLE_ADDR, UKIRQ_MASK_ADDR,
      UKIRQ_STATUS_ADDR, UKIRQ_SUSRES_ADDR, UKIRQ_SUSRES_EN_ADDR, UKIRQ_SLEEP_CTRL_ADDR,
      UKIRQ_CORE_CTRL_ADDR, UKIRQ_ACK_ADDR, 16'h1ff4};
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (regs[i]) rc(regs[i], UKIRQ_RESET_VAL, 8'hbf);
    wr(UKIRQ_ENABLE_ADDR, 8'hff);
    rc(UKIRQ_ENABLE_ADDR, UKIRQ_USB_IMPL, 8'hff);
    st = 8'h0;
    for (int i = 0; i < 4; i++)
    begin
      ev = 4'h1 << ($random(seed) & 3);
      @(posedge hclk);
      if (i == 3) hub_ep0_evt <= ev; else func_ep_evt[i] <= ev;
      @(posedge hclk);
      hub_ep0_evt <= '0;
      func_ep_evt <= '0;
      st = st | ep_bit(i);
      rc(UKIRQ_STATUS_ADDR, st, 8'hbf);
      chk("usb request", usb_irq_req, 1);
    end
    wr(UKIRQ_MASK_ADDR, 8'hff);
    rc(UKIRQ_MASK_ADDR, UKIRQ_USB_IMPL, 8'hff);
    chk("usb request", usb_irq_req, 0);
    wr(UKIRQ_MASK_ADDR, st | 8'h40);
    @(posedge hclk);
    sof_frame_num <= 11'($random(seed));
    sof_valid <= 1'b1;
    @(posedge hclk);
    sof_valid <= 1'b0;
    st = st | 8'h80;
    rc(UKIRQ_STATUS_ADDR, st, 8'hbf);
    chk("frame number", frame_number, {5'h0, sof_frame_num});
    chk("usb request", usb_irq_req, 1);
    ack = 8'($random(seed)) & st;
    wr(UKIRQ_ACK_ADDR, ack);
    rc(UKIRQ_STATUS_ADDR, st & ~ack, 8'hbf);
    wr(UKIRQ_ACK_ADDR, 8'hff);
    rc(UKIRQ_STATUS_ADDR, 8'h00, 8'hbf);
    repeat (FRAME_CLOCKS + 2) @(posedge hclk);
    rc(UKIRQ_STATUS_ADDR, 8'h40, 8'h40);
    wr(UKIRQ_ENABLE_ADDR, 8'h00);
    @(posedge hclk);
    function_wakeup_request <= 1'b1;
    global_suspend_event <= 1'b1;
    resume_event <= 1'b1;
    @(posedge hclk);
    function_wakeup_request <= 1'b0;
    global_suspend_event <= 1'b0;
    resume_event <= 1'b0;
    rc(UKIRQ_SUSRES_ADDR, UKIRQ_SUSRES_IMPL, 8'hff);
    wr(UKIRQ_SUSRES_EN_ADDR, 8'h77);
    chk("susres request", susres_irq_req, 1);
    wr(UKIRQ_SUSRES_ADDR, 8'h06);
    rc(UKIRQ_SUSRES_ADDR, 8'h06, 8'hff);
    wr(UKIRQ_SUSRES_ADDR, 8'h00);
    rc(UKIRQ_SUSRES_ADDR, 8'h00, 8'hff);
    @(posedge hclk);
    in_suspend <= 1'b1;
    key_rows_n[$random(seed) & 7] <= 1'b0;
    repeat (4) @(posedge hclk);
    rc(UKIRQ_SUSRES_ADDR, 8'h02, 8'hff);
    @(posedge hclk);
    key_rows_n <= 8'hff;
    in_suspend <= 1'b0;
    // a pending resume request would wake the core at once
    wr(UKIRQ_SUSRES_ADDR, 8'h00);
    for (int k = 0; k < 2; k++)
    begin
      @(posedge hclk);
      timer_overflow <= 1'b1;
      @(posedge hclk);
      timer_overflow <= 1'b0;
      rc(UKIRQ_TIMER_FLAGS_ADDR, 8'h02, 8'hff);
      wr(UKIRQ_TIMER_FLAGS_ADDR, k ? 8'h02 : 8'hfd);
      rc(UKIRQ_TIMER_FLAGS_ADDR, k ? 8'h00 : 8'h02, 8'hff);
    end
    wr(UKIRQ_CORE_CTRL_ADDR, 8'h02);
    @(posedge hclk);
    timer_overflow <= 1'b1;
    @(posedge hclk);
    timer_overflow <= 1'b0;
    repeat (10) @(posedge hclk);
    chk("stall", in_irq_seq, 0);
    sp0 = stack_ptr;
    pushed = 1'b0;
    wr(UKIRQ_CORE_CTRL_ADDR, 8'h82);
    repeat (40)
    begin
      @(posedge hclk);
      if (stack_ptr === sp0 - 16'h2) pushed = 1'b1;
    end
    chk("push", pushed, 1);
    chk("stack", stack_ptr, sp0);
    chk("global enable", global_irq_enable, 1);
    rc(UKIRQ_TIMER_FLAGS_ADDR, 8'h00, 8'hff);
    for (int k = 0; k < 2; k++)
    begin
      wr(UKIRQ_SLEEP_CTRL_ADDR, k ? 8'h30 : 8'h10);
      @(posedge hclk);
      sleep_go <= 1'b1;
      @(posedge hclk);
      sleep_go <= 1'b0;
      repeat (4) @(posedge hclk);
      chk("sleep", sleep_power_down, k[0]);
    end
    conclude();
  end
endmodule
